// File: src/dmh_handshake.sv
// Operation
// - start only on trigger rising edge while not faulted
// - ignore trigger changes until the running operation completes
// - accepted trigger runs selected mode, dispense or prime
// - ready asserted exactly when idle and unfaulted, and under the loaded definition only when no load is needed
// - ready held low through any operation and while faulted
// - host-selected definition of ready drives the ready output
// - fault output active low, high while fault-free
// - fault raised only on the fourth stall within one operation
// - load-required high while any enabled channel needs or runs load
// - load-required low when no enabled channel needs or runs load
// - with encoder, any encoder stall counts immediately
// - without encoder, rotary fault only if valving to A unanswered
// - without encoder, linear home fault only during load
// - outputs conduct for true, fault output inverted
// - contact variant reads closed contact as trigger true
`timescale 1ns/1ps
`default_nettype none
`include "dmh_regs.svh"

module dmh_handshake (
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic                    start_request_pin,
    input  wire logic                    contactVariant,
    input  wire logic                    contactClosed,
    input  wire dmh_pkg::dmh_op_mode_e   opModeSel,
    input  wire dmh_pkg::dmh_ready_def_e readyDef,
    input  wire logic                    encoderFitted,
    input  wire dmh_pkg::dmh_sense_s     sense,
    input  wire dmh_pkg::dmh_load_s      loadStat,
    input  wire logic                    opDone,
    input  wire logic                    operatorReset,
    output var  logic                    opStart,
    output var  dmh_pkg::dmh_op_mode_e   opMode,
    output var  logic                    readyOut,
    output var  logic                    faultOut_n,
    output var  logic                    loadRequiredOut,
    output var  logic                    busy
);
    typedef struct packed {
        dmh_pkg::dmh_state_e   state;
        dmh_pkg::dmh_op_mode_e mode;
        logic [2:0]            stalls;
        logic                  faulted;
        logic                  start;
        logic                  ready;
        logic                  faultN;
        logic                  loadReq;
        logic                  busy;
    } dmh_hs_s;

    localparam logic [2:0] STALL_LIMIT = `DMH_STALL_LIMIT;

    dmh_hs_s st;
    dmh_hs_s next_st;
    logic    trigLevel;
    logic    trigRise;
    logic    stallHit;
    logic    anyLoad;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    function automatic logic readyFor(input dmh_pkg::dmh_ready_def_e def,
                                      input logic idle,
                                      input logic flt,
                                      input logic needLoad);
        case (def)
            dmh_pkg::READY_IDLE_OK:     readyFor = idle && !flt;
            dmh_pkg::READY_IDLE_LOADED: readyFor = idle && !flt && !needLoad;
            dmh_pkg::READY_IDLE_ONLY:   readyFor = idle && !flt;
            default:                    readyFor = idle && !flt;
        endcase
    endfunction

    assign trigLevel = contactVariant ? contactClosed : start_request_pin;

    dmh_trigger_filter u_filter (
        .core_clk  (core_clk),
        .rst       (rst),
        .rawIn     (trigLevel),
        .risePulse (trigRise)
    );

    always_comb begin
        if (encoderFitted) begin
            stallHit = sense.motorStall || sense.encoderStall;
        end else begin
            stallHit = (sense.valveToA && !sense.rotaryHomeSeen)
                     || (sense.loadActive && !sense.linearHomeSeen);
        end
    end

    assign anyLoad = |(loadStat.chanEnable & (loadStat.chanNeedLoad | loadStat.chanLoading));

    always_comb begin
        next_st       = st;
        next_st.start = 1'b0;
        case (st.state)
            dmh_pkg::ST_IDLE: begin
                if (trigRise && !st.faulted) begin
                    next_st.state  = dmh_pkg::ST_RUN;
                    next_st.mode   = opModeSel;
                    next_st.start  = 1'b1;
                    next_st.stalls = '0;
                end
            end
            dmh_pkg::ST_RUN: begin
                if (stallHit && st.stalls < STALL_LIMIT) begin
                    next_st.stalls = st.stalls + 1'b1;
                end
                if (stallHit && st.stalls == STALL_LIMIT - 1'b1) begin
                    next_st.faulted = 1'b1;
                end
                if (opDone) begin
                    next_st.state = dmh_pkg::ST_WAIT_DONE;
                end
            end
            dmh_pkg::ST_WAIT_DONE: begin
                next_st.state = dmh_pkg::ST_IDLE;
            end
            default: begin
                next_st.state = dmh_pkg::ST_IDLE;
            end
        endcase
        // operator reset is ignored mid-run, so a stall in that cycle keeps the fault
        if (operatorReset && st.state != dmh_pkg::ST_RUN) begin
            next_st.faulted = 1'b0;
        end
        next_st.ready   = readyFor(readyDef, next_st.state == dmh_pkg::ST_IDLE,
                                   next_st.faulted, anyLoad);
        next_st.faultN  = !next_st.faulted;
        next_st.loadReq = anyLoad;
        next_st.busy    = next_st.state != dmh_pkg::ST_IDLE;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st        <= '0;
            st.faultN <= !`DMH_FAULT_RST;
        end else begin
            st <= next_st;
        end
    end

    assign opStart         = st.start;
    assign opMode          = st.mode;
    assign readyOut        = st.ready;
    assign faultOut_n      = st.faultN;
    assign loadRequiredOut = st.loadReq;
    assign busy            = st.busy;

    sequence accepted_s;
        trigRise && st.state == dmh_pkg::ST_IDLE && !st.faulted;
    endsequence

    sequence finished_s;
        st.state == dmh_pkg::ST_RUN && opDone;
    endsequence

    sequence lastStall_s;
        st.state == dmh_pkg::ST_RUN && stallHit && st.stalls == STALL_LIMIT - 3'h1;
    endsequence

    sequence encStall_s;
        st.state == dmh_pkg::ST_RUN && encoderFitted && st.stalls < STALL_LIMIT
        && (sense.encoderStall || sense.motorStall);
    endsequence

    sequence sensorMiss_s;
        st.state == dmh_pkg::ST_RUN && !encoderFitted && st.stalls < STALL_LIMIT
        && ((sense.valveToA && !sense.rotaryHomeSeen) || (sense.loadActive && !sense.linearHomeSeen));
    endsequence

    sequence sensorQuiet_s;
        st.state == dmh_pkg::ST_RUN && !encoderFitted
        && !(sense.valveToA && !sense.rotaryHomeSeen) && !(sense.loadActive && !sense.linearHomeSeen);
    endsequence

    // start and retrigger handling
    startOnEdge_a: assert property (accepted_s |=> opStart && busy)
        else $error("accepted trigger did not start");
    noStartFault_a: assert property (st.faulted |=> !opStart)
        else $error("start while faulted");
    startOnce_a: assert property (opStart |=> !opStart)
        else $error("start pulse longer than one cycle");
    ignoreWhileBusy_a: assert property (busy |=> !opStart)
        else $error("retrigger during operation");
    opComplete_a: assert property (finished_s |=> busy ##1 !busy)
        else $error("operation did not complete in two cycles");
    modeLatched_a: assert property (accepted_s |=> opMode == $past(opModeSel))
        else $error("wrong mode launched");
    modeHold_a: assert property (busy && !opStart |-> $stable(opMode))
        else $error("mode changed during operation");

    // ready output
    readyBusy_a: assert property (opStart |-> !readyOut)
        else $error("ready during operation");
    readyRun_a: assert property (busy |-> !readyOut)
        else $error("ready while busy");
    readyFault_a: assert property (st.faulted |-> !readyOut)
        else $error("ready while faulted");
    readyIdle_a: assert property (readyOut |-> !busy && !st.faulted)
        else $error("ready without idle");
    readyExact_a: assert property (
        !$past(rst) && !busy && !st.faulted && $past(readyDef) != dmh_pkg::READY_IDLE_LOADED |-> readyOut)
        else $error("ready missing while idle");
    readyLoaded_a: assert property (
        $past(readyDef) == dmh_pkg::READY_IDLE_LOADED && $past(anyLoad) |-> !readyOut)
        else $error("ready while load needed");

    // fault output and stall counting
    faultLevel_a: assert property (faultOut_n == !st.faulted)
        else $error("fault output sense wrong");
    fourthStall_a: assert property ($rose(st.faulted) |-> st.stalls == STALL_LIMIT)
        else $error("fault before fourth stall");
    fourthFault_a: assert property (lastStall_s |=> !faultOut_n && !readyOut)
        else $error("fourth stall did not fault");
    earlyFault_a: assert property (
        st.state == dmh_pkg::ST_RUN && !st.faulted && st.stalls < STALL_LIMIT - 3'h1 |=> faultOut_n)
        else $error("fault output fell early");
    encoderCount_a: assert property (encStall_s |=> st.stalls == $past(st.stalls) + 3'h1)
        else $error("encoder stall not counted");
    sensorCount_a: assert property (sensorMiss_s |=> st.stalls == $past(st.stalls) + 3'h1)
        else $error("home sensor stall not counted");
    sensorGate_a: assert property (sensorQuiet_s |=> $stable(st.stalls))
        else $error("stall counted without sensor miss");
    faultHeld_a: assert property (
        st.faulted && !(operatorReset && st.state != dmh_pkg::ST_RUN) |=> !faultOut_n)
        else $error("fault dropped without reset");
    faultClear_a: assert property (operatorReset && st.state != dmh_pkg::ST_RUN |=> faultOut_n)
        else $error("operator reset did not clear fault");

    // load required output
    loadReq_a: assert property (anyLoad |=> loadRequiredOut)
        else $error("load required missing");
    loadIdle_a: assert property (!anyLoad |=> !loadRequiredOut)
        else $error("load required stuck");
endmodule

`default_nettype wire

// File: src/dmh_regs.svh
`ifndef DMH_REGS_SVH
`define DMH_REGS_SVH

`define DMH_STALL_LIMIT      3'h4
`define DMH_DEBOUNCE_NS      100000
`define DMH_CLK_NS           25
`define DMH_DEBOUNCE_CYC     ((`DMH_DEBOUNCE_NS + `DMH_CLK_NS - 1) / `DMH_CLK_NS)
`define DMH_DEB_W            16
`define DMH_FAULT_RST        1'b0

`endif

// File: src/dmh_pkg.sv
package dmh_pkg;
    typedef enum logic [1:0] {
        READY_IDLE_OK,
        READY_IDLE_LOADED,
        READY_IDLE_ONLY
    } dmh_ready_def_e;

    typedef enum logic {
        MODE_DISPENSE,
        MODE_PRIME
    } dmh_op_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_WAIT_DONE
    } dmh_state_e;

    typedef struct packed {
        logic motorStall;
        logic encoderStall;
        logic valveToA;
        logic rotaryHomeSeen;
        logic loadActive;
        logic linearHomeSeen;
    } dmh_sense_s;

    typedef struct packed {
        logic [1:0] chanEnable;
        logic [1:0] chanNeedLoad;
        logic [1:0] chanLoading;
    } dmh_load_s;
endpackage

// File: src/dmh_trigger_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmh_regs.svh"

module dmh_trigger_filter (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic rawIn,
    output var  logic risePulse
);
    typedef struct packed {
        logic                  sync1;
        logic                  sync2;
        logic                  stable;
        logic [`DMH_DEB_W-1:0] count;
        logic                  rise;
    } dmh_filt_s;

    localparam logic [`DMH_DEB_W-1:0] DEB_CYC = `DMH_DEB_W'(`DMH_DEBOUNCE_CYC);

    dmh_filt_s st;
    dmh_filt_s next_st;

    always_comb begin
        next_st       = st;
        next_st.sync1 = rawIn;
        next_st.sync2 = st.sync1;
        next_st.rise  = 1'b0;
        if (st.sync2 == st.stable) begin
            next_st.count = '0;
        end else if (st.count >= DEB_CYC - 1'b1) begin
            next_st.count  = '0;
            next_st.stable = st.sync2;
            next_st.rise   = st.sync2;
        end else begin
            next_st.count = st.count + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign risePulse = st.rise;

    riseOnce_a: assert property (@(posedge core_clk) disable iff (rst)
        st.rise |=> !st.rise) else $error("rise pulse longer than one cycle");
endmodule

`default_nettype wire

// File: verif/dmh_motion_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmh_motion_model (
    input  wire logic                    core_clk,
    input  wire logic                    pressReq,
    input  wire logic                    contactMode,
    input  wire dmh_pkg::dmh_ready_def_e readyCfg,
    output var  logic                    trigPin,
    output var  logic                    contactClosed,
    output var  dmh_pkg::dmh_ready_def_e readyDef
);
    initial begin
        trigPin = 1'b0;
        contactClosed = 1'b0;
        readyDef = dmh_pkg::READY_IDLE_OK;
    end
    // levels move on the falling edge only
    always @(negedge core_clk) begin
        trigPin <= pressReq & ~contactMode;
        contactClosed <= pressReq & contactMode;
        readyDef <= readyCfg;
    end
endmodule
`default_nettype wire

// File: verif/dmh_handshake_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmh_regs.svh"
module dmh_handshake_tb_top;
    localparam int DEB = `DMH_DEBOUNCE_CYC;
    logic core_clk, rst, pressReq, contactMode, trigPin, contactClosed;
    logic encoderFitted, opDone, operatorReset;
    logic opStart, readyOut, faultOut_n, loadRequiredOut, busy;
    dmh_pkg::dmh_op_mode_e   opModeSel, opMode;
    dmh_pkg::dmh_ready_def_e readyCfg, readyDef;
    dmh_pkg::dmh_sense_s     sense;
    dmh_pkg::dmh_load_s      loadStat;
    int err_total = 0;
    int checked = 0;
    int starts = 0;
    logic [5:0] ldTab [4] = '{6'h18, 6'h14, 6'h11, 6'h00};
    logic       ldExp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

    dmh_motion_model dmh_motion_model_inst (.core_clk(core_clk), .pressReq(pressReq),
        .contactMode(contactMode), .readyCfg(readyCfg), .trigPin(trigPin),
        .contactClosed(contactClosed), .readyDef(readyDef));
    dmh_handshake dmh_handshake_inst (.core_clk(core_clk), .rst(rst), .start_request_pin(trigPin),
        .contactVariant(contactMode), .contactClosed(contactClosed), .opModeSel(opModeSel),
        .readyDef(readyDef), .encoderFitted(encoderFitted), .sense(sense), .loadStat(loadStat),
        .opDone(opDone), .operatorReset(operatorReset), .opStart(opStart), .opMode(opMode),
        .readyOut(readyOut), .faultOut_n(faultOut_n), .loadRequiredOut(loadRequiredOut), .busy(busy));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (opStart === 1'b1) starts++;

    task automatic chk(input logic [1:0] seen, input logic [1:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s seen %b expected %b", $time, what, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic wait_start(input int lim);
        int n;
        n = 0;
        while (opStart !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
        chk(opStart, 1'b1, "start pulse");
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic t_idle_load();
        chk(faultOut_n, 1'b1, "fault idle");
        chk(readyOut, 1'b1, "ready idle");
        for (int i = 0; i < 4; i++) begin
            loadStat = ldTab[i];
            cyc(2);
            chk(loadRequiredOut, ldExp[i], "load req");
        end
        loadStat = 6'h14;
        readyCfg = dmh_pkg::READY_IDLE_LOADED;
        cyc(3);
        chk(readyOut, 1'b0, "ready loaded def");
        readyCfg = dmh_pkg::READY_IDLE_ONLY;
        cyc(3);
        chk(readyOut, 1'b1, "ready idle def");
        loadStat = '0;
        readyCfg = dmh_pkg::READY_IDLE_OK;
        cyc(3);
    endtask

    task automatic t_prime_fault();
        contactMode = 1'b1;
        opModeSel = dmh_pkg::MODE_PRIME;
        encoderFitted = 1'b1;
        pressReq = 1'b1;
        wait_start(DEB + 200);
        cyc(1);
        pressReq = 1'b0;
        chk(opMode, dmh_pkg::MODE_PRIME, "mode prime");
        chk({readyOut, busy}, 2'b01, "ready in run");
        sense.encoderStall = 1'b1;
        cyc(3);
        sense.encoderStall = 1'b0;
        cyc(3);
        chk(faultOut_n, 1'b1, "three stalls");
        sense.encoderStall = 1'b1;
        cyc(1);
        sense.encoderStall = 1'b0;
        cyc(3);
        chk(faultOut_n, 1'b0, "fourth stall");
        opDone = 1'b1;
        cyc(1);
        opDone = 1'b0;
        cyc(4);
        chk({readyOut, busy}, 2'b00, "ready faulted");
        operatorReset = 1'b1;
        cyc(1);
        operatorReset = 1'b0;
        cyc(3);
        chk({faultOut_n, readyOut}, 2'b11, "fault cleared");
    endtask

    task automatic t_dispense_plain();
        int s0;
        contactMode = 1'b0;
        opModeSel = dmh_pkg::MODE_DISPENSE;
        encoderFitted = 1'b0;
        cyc(DEB + 10);
        pressReq = 1'b1;
        wait_start(DEB + 200);
        cyc(1);
        s0 = starts;
        chk(opMode, dmh_pkg::MODE_DISPENSE, "mode dispense");
        sense = 6'h3F;
        cyc(6);
        sense = '0;
        cyc(3);
        chk(faultOut_n, 1'b1, "no encoder stall");
        pressReq = 1'b0;
        cyc(DEB + 10);
        pressReq = 1'b1;
        cyc(DEB + 10);
        chk(busy, 1'b1, "busy at retrigger");
        opDone = 1'b1;
        cyc(1);
        opDone = 1'b0;
        cyc(4);
        chk({readyOut, busy}, 2'b10, "ready after op");
        chk(starts - s0 == 0, 1'b1, "no restart");
    endtask

    task automatic t_reset_fault();
        pressReq = 1'b0;
        cyc(DEB + 10);
        pressReq = 1'b1;
        wait_start(DEB + 200);
        sense = 6'h02;
        cyc(2);
        sense = 6'h08;
        cyc(2);
        sense = '0;
        cyc(2);
        chk(faultOut_n, 1'b0, "sensor stalls");
        rst = 1'b1;
        pressReq = 1'b0;
        cyc(2);
        chk({opStart, readyOut}, 2'b00, "outputs in reset");
        chk({faultOut_n, loadRequiredOut}, 2'b10, "fault in reset");
        rst = 1'b0;
        cyc(2);
        chk({faultOut_n, readyOut}, 2'b11, "ready after reset");
        chk(busy, 1'b0, "idle after reset");
    endtask

    initial begin
        rst = 1'b1;
        {pressReq, contactMode, encoderFitted, opDone, operatorReset} = '0;
        opModeSel = dmh_pkg::MODE_DISPENSE;
        readyCfg = dmh_pkg::READY_IDLE_OK;
        sense = '0;
        loadStat = '0;
        cyc(4);
        rst = 1'b0;
        cyc(3);
        t_idle_load();
        t_prime_fault();
        t_dispense_plain();
        t_reset_fault();
        stop_test();
    end
    initial begin
        repeat (10 * DEB + 5000) @(posedge core_clk);
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
